// ===== core/srctl_pkg.sv
// Constants for the system reset controller.
// Assumes a single 200 MHz clock and an AXI4-Lite register port.
package srctl_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] SRCTL_CAUSE_OFS = 8'h00;
    localparam logic [7:0] SRCTL_CTRL_OFS = 8'h04;
    localparam logic [7:0] SRCTL_PRST_OFS = 8'h08;
    localparam logic [7:0] SRCTL_ALTF_OFS = 8'h0C;
    localparam logic [7:0] SRCTL_LOCK_OFS = 8'h10;
    localparam logic [7:0] SRCTL_COMMIT_OFS = 8'h14;
    localparam logic [7:0] SRCTL_IDA_OFS = 8'h20;
    localparam logic [7:0] SRCTL_IDB_OFS = 8'h24;
    localparam logic [7:0] SRCTL_CAP_OFS = 8'h28;
    // ==========================================================
    // Cause bit positions
    localparam int SRCTL_C_EXT = 0;
    localparam int SRCTL_C_POR = 1;
    localparam int SRCTL_C_BOR = 2;
    localparam int SRCTL_C_WDT = 3;
    localparam int SRCTL_C_SW = 4;
    localparam int SRCTL_C_OSC = 5;
    localparam int SRCTL_NCAUSE = 6;
    // Control bit positions
    localparam int SRCTL_B_SYSREQ = 0;
    localparam int SRCTL_B_BOREN = 1;
    localparam int SRCTL_B_WDTEN = 2;
    // ==========================================================
    // Reset values and keys
    localparam logic [31:0] SRCTL_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SRCTL_UNLOCK_KEY = 32'h4C4F_434B;
    // Arbitrary identification values
    localparam logic [31:0] SRCTL_IDA_VAL = 32'h0001_0000;
    localparam logic [31:0] SRCTL_IDB_VAL = 32'h0000_1111;
    localparam logic [31:0] SRCTL_CAP_VAL = 32'h0000_0000;
    // ==========================================================
    // Timing
    localparam int SRCTL_CLK_MHZ = 200;
    localparam int SRCTL_HOLD_NS = 50;
    localparam int SRCTL_HOLD_CYC = (SRCTL_HOLD_NS * SRCTL_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] SRCTL_FETCH_STEPS = 3'h3;
    typedef enum logic [2:0] {
        SRCTL_S_RESET = 3'b000,
        SRCTL_S_HOLD = 3'b001,
        SRCTL_S_SP = 3'b010,
        SRCTL_S_PC = 3'b011,
        SRCTL_S_INSN = 3'b100,
        SRCTL_S_RUN = 3'b101
    } srctl_state_t;
endpackage : srctl_pkg

// ===== core/srctl_sync.sv
// Reset-pin synchroniser: asynchronous assert, synchronous release.
// Assumes clk is free running.
`timescale 1ns/1ps
module srctl_sync (
    input wire logic aclk,
    input wire logic pin_n,
    output logic sync_n
);
    logic stage1_n;
    // Async assert is a constant load only
    always_ff @(posedge aclk or negedge pin_n) begin
        if (!pin_n) begin
            stage1_n <= 1'b0;
            sync_n <= 1'b0;
        end else begin
            stage1_n <= 1'b1;
            sync_n <= stage1_n;
        end
    end
endmodule : srctl_sync

// ===== core/srctl_top.sv
// System reset controller: combines reset sources, keeps cause flags,
// sequences the core start fetch, owns the NMI pin mux.
// Assumes detectors deliver levels synchronous to aclk.
`timescale 1ns/1ps
module srctl_top
    import srctl_pkg::*;
#(
    parameter int NPERIPH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic por_active,
    input wire logic reset_pin_n,
    input wire logic brownout_detect,
    input wire logic wdt_second_timeout,
    input wire logic main_oscillator_fail,
    input wire logic core_fetch_done,
    input wire logic nmi_pin,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_reset_n,
    output logic tap_reset_n,
    output logic tap_pincfg_reset_n,
    output logic [NPERIPH-1:0] periph_reset_n,
    output logic [1:0] fetch_step,
    output logic nmi_out
);
    initial begin
        if (NPERIPH < 1 || NPERIPH > 32) $error("NPERIPH must be 1..32");
    end

    // ==========================================================
    // Source combination
    logic pin_sync_n;
    logic por_seen;
    logic sysreq;
    logic sysreq_q;
    logic [NPERIPH-1:0] prst;
    logic [NPERIPH-1:0] prst_q;
    logic [SRCTL_NCAUSE-1:0] reset_cause_reg;
    logic brownout_reset_enable;
    logic wdt_reset_enable;
    logic alt_function_select;
    logic unlocked;
    logic commit;
    srctl_state_t state;
    srctl_state_t next_state;
    logic [7:0] hold_cnt;

    srctl_sync u_sync (
        .aclk(aclk),
        .pin_n(reset_pin_n),
        .sync_n(pin_sync_n)
    );

    // Power-on source only counts before first release
    wire por_src = por_active && !por_seen;
    wire pin_src = !pin_sync_n;
    wire bor_src = brownout_detect && brownout_reset_enable;
    wire wdt_src = wdt_second_timeout && wdt_reset_enable;
    wire osc_src = main_oscillator_fail;
    wire sw_src = sysreq;
    wire [SRCTL_NCAUSE-1:0] src_vec = {osc_src, sw_src, wdt_src, bor_src, por_src, pin_src};
    wire any_src = |src_vec;
    // Core/peripheral system reset
    wire sys_rst = any_src || !aresetn;
    wire [NPERIPH-1:0] prst_fall = prst_q & ~prst;

    // ==========================================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            SRCTL_S_RESET: next_state = SRCTL_S_HOLD;
            SRCTL_S_HOLD: if (hold_cnt >= 8'(SRCTL_HOLD_CYC)) next_state = SRCTL_S_SP;
            SRCTL_S_SP: if (core_fetch_done) next_state = SRCTL_S_PC;
            SRCTL_S_PC: if (core_fetch_done) next_state = SRCTL_S_INSN;
            SRCTL_S_INSN: if (core_fetch_done) next_state = SRCTL_S_RUN;
            SRCTL_S_RUN: next_state = SRCTL_S_RUN;
            default: next_state = SRCTL_S_RESET;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            state <= SRCTL_S_RESET;
            hold_cnt <= 8'h00;
        end else if (clk_en) begin
            state <= next_state;
            hold_cnt <= (state == SRCTL_S_HOLD) ? hold_cnt + 8'h01 : 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (clk_en && !por_active && state == SRCTL_S_SP) por_seen <= 1'b1;
        else if (!aresetn) por_seen <= 1'b0;
    end

    // Core held until sequencer leaves hold
    assign core_reset_n = (state != SRCTL_S_RESET) && (state != SRCTL_S_HOLD);
    assign tap_reset_n = !(por_src || !aresetn);
    assign tap_pincfg_reset_n = !(por_src || pin_src || !aresetn);
    // Peripheral release follows the core
    assign periph_reset_n = core_reset_n ? ~prst_fall : {NPERIPH{1'b0}};
    assign fetch_step = (state == SRCTL_S_SP) ? 2'h1 : (state == SRCTL_S_PC) ? 2'h2 :
                        (state == SRCTL_S_INSN) ? 2'h3 : 2'h0;
    assign nmi_out = alt_function_select && nmi_pin;

    // ==========================================================
    // Cause flags: set wins, pin/POR clear others
    wire clr_others = por_src || pin_src;
    wire [SRCTL_NCAUSE-1:0] keep = clr_others ? '0 : reset_cause_reg;
    logic cause_wr;
    logic [SRCTL_NCAUSE-1:0] cause_wval;
    wire [SRCTL_NCAUSE-1:0] base = cause_wr ? cause_wval : keep;
    always_ff @(posedge aclk) begin
        if (clk_en) reset_cause_reg <= base | src_vec;
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_hold;
    logic w_hold;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire aw_ok = aw_hold || (s_axi_awvalid && s_axi_awready);
    wire w_ok = w_hold || (s_axi_wvalid && s_axi_wready);
    wire [7:0] wa = aw_hold ? aw_q : s_axi_awaddr[7:0];
    wire [31:0] wd = w_hold ? w_q : s_axi_wdata;
    wire do_wr = aw_ok && w_ok && clk_en;
    wire wr_cause = do_wr && wa == SRCTL_CAUSE_OFS;
    wire wr_ctrl = do_wr && wa == SRCTL_CTRL_OFS;
    wire wr_prst = do_wr && wa == SRCTL_PRST_OFS;
    wire wr_altf = do_wr && wa == SRCTL_ALTF_OFS && unlocked && commit;
    wire wr_lock = do_wr && wa == SRCTL_LOCK_OFS;
    wire wr_commit = do_wr && wa == SRCTL_COMMIT_OFS && unlocked;
    assign cause_wr = wr_cause;
    assign cause_wval = wd[SRCTL_NCAUSE-1:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr[7:0];
            if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
            aw_hold <= aw_ok && !do_wr;
            w_hold <= w_ok && !do_wr;
            if (do_wr) s_axi_bvalid <= 1'b1;
            else if (s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_bresp = 2'b00;

    // Enables survive their own resets: a held brown-out keeps the core in reset
    always_ff @(posedge aclk) begin
        if (por_src || !aresetn) begin
            brownout_reset_enable <= SRCTL_CTRL_RST[SRCTL_B_BOREN];
            wdt_reset_enable <= SRCTL_CTRL_RST[SRCTL_B_WDTEN];
        end else if (wr_ctrl) begin
            brownout_reset_enable <= wd[SRCTL_B_BOREN];
            wdt_reset_enable <= wd[SRCTL_B_WDTEN];
        end
    end

    always_ff @(posedge aclk) begin
        if (sys_rst) begin
            sysreq <= 1'b0;
            prst <= '0;
            prst_q <= '0;
            alt_function_select <= 1'b0;
            unlocked <= 1'b0;
            commit <= 1'b0;
        end else if (clk_en) begin
            prst_q <= prst;
            if (wr_ctrl) sysreq <= wd[SRCTL_B_SYSREQ];
            if (wr_prst) prst <= wd[NPERIPH-1:0];
            if (wr_lock) unlocked <= (wd == SRCTL_UNLOCK_KEY);
            if (wr_commit) commit <= wd[0];
            if (wr_altf) alt_function_select <= wd[0];
        end
    end

    wire [7:0] ra = s_axi_araddr[7:0];
    wire [31:0] rd_val =
        (ra == SRCTL_CAUSE_OFS) ? {26'h0, reset_cause_reg} :
        (ra == SRCTL_CTRL_OFS) ? {29'h0, wdt_reset_enable, brownout_reset_enable, sysreq} :
        (ra == SRCTL_PRST_OFS) ? 32'(prst) :
        (ra == SRCTL_ALTF_OFS) ? {31'h0, alt_function_select} :
        (ra == SRCTL_LOCK_OFS) ? {31'h0, unlocked} :
        (ra == SRCTL_COMMIT_OFS) ? {31'h0, commit} :
        (ra == SRCTL_IDA_OFS) ? SRCTL_IDA_VAL :
        (ra == SRCTL_IDB_OFS) ? SRCTL_IDB_VAL :
        (ra == SRCTL_CAP_OFS) ? SRCTL_CAP_VAL : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_rresp = 2'b00;

    // ==========================================================
    // Checks
    core_held_a: assert property (@(posedge aclk) any_src |=> !core_reset_n)
        else $error("core released while a source active");
    tap_por_a: assert property (@(posedge aclk) disable iff (!aresetn) por_src |-> !tap_reset_n)
        else $error("test port not reset on power-on");
    tap_pin_a: assert property (@(posedge aclk) disable iff (!aresetn) (pin_src && !por_src) |-> tap_reset_n)
        else $error("pin reset hit test port");
    cause_set_a: assert property (@(posedge aclk) disable iff (!aresetn) (clk_en && wdt_src) |=> reset_cause_reg[SRCTL_C_WDT])
        else $error("watchdog cause not flagged");
    cause_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && pin_src && !cause_wr && !bor_src) |=> !reset_cause_reg[SRCTL_C_BOR])
        else $error("pin reset did not clear others");
    cause_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && !clr_others && !cause_wr && reset_cause_reg[SRCTL_C_SW]) |=> reset_cause_reg[SRCTL_C_SW])
        else $error("sticky cause lost");
    bor_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) !brownout_reset_enable |-> !bor_src)
        else $error("brown-out reset while disabled");
    fetch_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == SRCTL_S_SP && clk_en && core_fetch_done && !sys_rst) |=> state == SRCTL_S_PC)
        else $error("fetch order broken");
    nmi_gpio_a: assert property (@(posedge aclk) !aresetn |=> !nmi_out)
        else $error("NMI active after reset");
    bor_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (bor_src && !por_src && !wr_ctrl) |=> brownout_reset_enable)
        else $error("brown-out enable lost while held");
    sys_periph_a: assert property (@(posedge aclk) sys_rst |=> periph_reset_n == '0)
        else $error("peripherals not reset with system");
    tap_sw_a: assert property (@(posedge aclk) disable iff (!aresetn) (sw_src && !por_src) |-> tap_reset_n)
        else $error("software request hit test port");
    osc_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && osc_src) |=> reset_cause_reg[SRCTL_C_OSC])
        else $error("oscillator cause not flagged");
    run_c: cover property (@(posedge aclk) state == SRCTL_S_RUN);
    pin_c: cover property (@(posedge aclk) pin_src ##[1:20] core_reset_n);
    prst_c: cover property (@(posedge aclk) |prst_fall);
    bor_c: cover property (@(posedge aclk) bor_src ##1 bor_src ##1 bor_src);
    nmi_c: cover property (@(posedge aclk) nmi_out);
endmodule : srctl_top

// ===== tb/srctl_board.sv
// Board reset circuit model driving the active-low reset pin.
// Assumes a pull-up on the pin, so the pin idles high.
`timescale 1ns/1ps
module srctl_board #(
    parameter int MIN_LOW = 4
) (
    input wire logic aclk,
    input wire logic press,
    input wire logic [7:0] hold_cyc,
    output logic reset_pin_n
);
    initial reset_pin_n = 1'b1;
    // Off-edge changes exercise the asynchronous path of the pin
    always @(posedge press) begin : hold_low
        int n;
        n = (int'(hold_cyc) < MIN_LOW) ? MIN_LOW : int'(hold_cyc);
        #1.7 reset_pin_n = 1'b0;
        repeat (n) @(posedge aclk);
        #1.7 reset_pin_n = 1'b1;
    end
endmodule : srctl_board

// ===== tb/testbench.sv
// Self-checking bench for the system reset controller.
// Assumes the board model on the reset pin and an AXI4-Lite master here.
`timescale 1ns/1ps
module testbench
    import srctl_pkg::*;
;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
    // ==========================================================
    // Signals
    logic aclk = 1'b0, aresetn = 1'b0, por_active = 1'b1, core_fetch_done = 1'b0, nmi_pin = 1'b0, press = 1'b0;
    logic [2:0] src = 3'h0;
    logic [7:0] hold_cyc = 8'h28;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, reset_pin_n, nmi_out;
    logic core_reset_n, tap_reset_n, tap_pincfg_reset_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, fetch_step;
    logic [31:0] s_axi_rdata;
    logic [7:0] periph_reset_n, plast;
    logic [5:0] cause_m = 6'h00;
    int n_fail = 0, total_checks = 0, seed = 32'h139c, plow = 0, k;
    always #2.5 aclk = ~aclk;
    srctl_top #(.NPERIPH(8)) uut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .por_active(por_active),
        .reset_pin_n(reset_pin_n), .brownout_detect(src[0]), .wdt_second_timeout(src[1]),
        .main_oscillator_fail(src[2]), .core_fetch_done(core_fetch_done), .nmi_pin(nmi_pin),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .core_reset_n(core_reset_n), .tap_reset_n(tap_reset_n),
        .tap_pincfg_reset_n(tap_pincfg_reset_n), .periph_reset_n(periph_reset_n), .fetch_step(fetch_step),
        .nmi_out(nmi_out));
    srctl_board #(.MIN_LOW(4)) board (.aclk(aclk), .press(press), .hold_cyc(hold_cyc), .reset_pin_n(reset_pin_n));
    // Soft peripheral reset pulses seen while the core runs
    always @(posedge aclk) if (core_reset_n === 1'b1 && periph_reset_n !== 8'hFF) begin
        plow++;
        plast = periph_reset_n;
    end
    // ==========================================================
    // Bus tasks: ready sampled at the falling edge, acted on at the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb && n < 200) begin
            @(negedge aclk);
            n++;
            ta = s_axi_awvalid && s_axi_awready === 1'b1;
            tw = s_axi_wvalid && s_axi_wready === 1'b1;
            tb = s_axi_bvalid === 1'b1;
            if (tb) `CHK(s_axi_bresp, 2'b00)
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        if (!tb) begin
            `CHK(1'b0, 1'b1)
            stop_test();
        end
        // One edge apart so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr && n < 200) begin
            @(negedge aclk);
            n++;
            ta = s_axi_arvalid && s_axi_arready === 1'b1;
            tr = s_axi_rvalid === 1'b1;
            v = s_axi_rdata;
            if (tr) `CHK(s_axi_rresp, 2'b00)
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
        if (!tr) begin
            `CHK(1'b0, 1'b1)
            stop_test();
        end
        @(posedge aclk);
    endtask : rd
    // ==========================================================
    // Reset helpers
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask : chk_rd
    task automatic wait_rst();
        int n;
        n = 0;
        while (core_reset_n !== 1'b0 && n < 100) begin
            @(negedge aclk);
            n++;
        end
        `CHK(core_reset_n, 1'b0)
        if (core_reset_n !== 1'b0) stop_test();
        `CHK(tap_reset_n, 1'b1)
        `CHK(periph_reset_n, 8'h00)
        @(posedge aclk);
    endtask : wait_rst
    task automatic boot();
        int n;
        n = 0;
        while (fetch_step !== 2'h1 && n < 200) begin
            @(negedge aclk);
            n++;
        end
        if (fetch_step !== 2'h1) begin
            n_fail++;
            stop_test();
        end
        for (int s = 1; s <= 3; s++) begin
            @(negedge aclk);
            `CHK(fetch_step, 2'(s))
            @(posedge aclk);
            core_fetch_done <= 1'b1;
            @(posedge aclk);
            core_fetch_done <= 1'b0;
        end
        @(negedge aclk);
        `CHK(fetch_step, 2'h0)
        `CHK(core_reset_n, 1'b1)
        @(posedge aclk);
    endtask : boot
    task automatic src_rst(input logic [2:0] v, input int len, input logic [31:0] ctl, input logic [5:0] add);
        wr(SRCTL_CTRL_OFS, ctl);
        src <= v;
        wait_rst();
        repeat (len) @(posedge aclk);
        @(negedge aclk);
        `CHK(core_reset_n, 1'b0)
        @(posedge aclk);
        src <= 3'h0;
        boot();
        cause_m = cause_m | add;
        chk_rd(SRCTL_CAUSE_OFS, {26'h0, cause_m});
        chk_rd(SRCTL_CTRL_OFS, ctl & ~(32'h1 << SRCTL_B_SYSREQ));
    endtask : src_rst
    task automatic no_rst(input logic [2:0] v);
        wr(SRCTL_CTRL_OFS, 32'h0);
        src <= v;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        `CHK(core_reset_n, 1'b1)
        @(posedge aclk);
        src <= 3'h0;
    endtask : no_rst
    task automatic pin_rst();
        hold_cyc <= 8'h28 + 8'($random(seed) & 15);
        press <= 1'b1;
        wait_rst();
        `CHK(tap_pincfg_reset_n, 1'b0)
        press <= 1'b0;
        repeat (30) @(posedge aclk);
        @(negedge aclk);
        `CHK(core_reset_n, 1'b0)
        @(posedge aclk);
        boot();
        cause_m = 6'h01;
        chk_rd(SRCTL_CAUSE_OFS, {26'h0, cause_m});
    endtask : pin_rst
    function automatic logic [5:0] bitm(input int i);
        return 6'h01 << i;
    endfunction : bitm
    task automatic endt(input string s);
        $display("test %s done", s);
    endtask : endt
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (30) @(posedge aclk);
        @(negedge aclk);
        `CHK(core_reset_n, 1'b0)
        `CHK(tap_reset_n, 1'b0)
        `CHK(periph_reset_n, 8'h00)
        @(posedge aclk);
        por_active <= 1'b0;
        boot();
        cause_m = bitm(SRCTL_C_POR);
        chk_rd(SRCTL_CAUSE_OFS, {26'h0, cause_m});
        wr(SRCTL_IDA_OFS, $random(seed));
        chk_rd(SRCTL_IDA_OFS, SRCTL_IDA_VAL);
        chk_rd(SRCTL_IDB_OFS, SRCTL_IDB_VAL);
        chk_rd(SRCTL_CAP_OFS, SRCTL_CAP_VAL);
        k = 32'h80 | ($random(seed) & 32'h7C);
        wr(8'(k), $random(seed));
        chk_rd(8'(k), 32'h0);
        endt("power-on");
        por_active <= 1'b1;
        no_rst(3'h0);
        por_active <= 1'b0;
        pin_rst();
        endt("pin");
        no_rst(3'b001);
        no_rst(3'b010);
        src_rst(3'b001, 20, 32'h2, bitm(SRCTL_C_BOR));
        src_rst(3'b010, 0, 32'h4, bitm(SRCTL_C_WDT));
        src_rst(3'b100, 0, 32'h0, bitm(SRCTL_C_OSC));
        src_rst(3'b110, 20, 32'h4, bitm(SRCTL_C_WDT) | bitm(SRCTL_C_OSC));
        src_rst(3'b000, 0, 32'h1, bitm(SRCTL_C_SW));
        endt("sources");
        for (int i = 0; i < 4; i++) begin
            k = (i == 0) ? 7 : ($random(seed) & 7);
            plow = 0;
            wr(SRCTL_PRST_OFS, 32'h1 << k);
            `CHK(plow, 0)
            wr(SRCTL_PRST_OFS, 32'h0);
            repeat (3) @(posedge aclk);
            `CHK(plow, 1)
            `CHK(plast, ~(8'h01 << k))
        end
        endt("peripheral");
        nmi_pin <= 1'b1;
        wr(SRCTL_ALTF_OFS, 32'h1);
        `CHK(nmi_out, 1'b0)
        wr(SRCTL_LOCK_OFS, SRCTL_UNLOCK_KEY);
        wr(SRCTL_COMMIT_OFS, 32'h1);
        wr(SRCTL_ALTF_OFS, 32'h1);
        @(negedge aclk);
        `CHK(nmi_out, 1'b1)
        @(posedge aclk);
        src_rst(3'b000, 0, 32'h1, bitm(SRCTL_C_SW));
        `CHK(nmi_out, 1'b0)
        endt("nmi");
        pin_rst();
        endt("flags cleared");
        stop_test();
    end
endmodule : testbench
